// >>> design/bst_pkg.sv
// Package with the constants and types of the boundary-scan test port.
package bst_pkg;

  // Controller states, Gray coded along the data and instruction paths.
  typedef enum logic [3:0] {
    BST_RESET      = 4'h0,
    BST_IDLE       = 4'h1,
    BST_SEL_DR     = 4'h3,
    BST_CAP_DR     = 4'h2,
    BST_SHIFT_DR   = 4'h6,
    BST_EXIT1_DR   = 4'h7,
    BST_PAUSE_DR   = 4'h5,
    BST_EXIT2_DR   = 4'h4,
    BST_UPD_DR     = 4'hc,
    BST_SEL_IR     = 4'hd,
    BST_CAP_IR     = 4'hf,
    BST_SHIFT_IR   = 4'he,
    BST_EXIT1_IR   = 4'ha,
    BST_PAUSE_IR   = 4'hb,
    BST_EXIT2_IR   = 4'h9,
    BST_UPD_IR     = 4'h8
  } bst_state_t;

  // Width of the instruction register.
  localparam int unsigned BST_IR_W = 4;

  // Instruction opcodes; bypass is all ones as usual.
  localparam logic [BST_IR_W-1:0] BST_OP_EXTEST  = 4'h0;
  localparam logic [BST_IR_W-1:0] BST_OP_SAMPLE  = 4'h1;
  localparam logic [BST_IR_W-1:0] BST_OP_BYPASS  = 4'hf;

  // Fixed capture pattern of the instruction register (low bits 01).
  localparam logic [BST_IR_W-1:0] BST_IR_CAPTURE = 4'h1;

  // Number of scanned digital pins in the boundary chain.
  localparam int unsigned BST_PINS = 8;

  // Sampled test pins travelling together.
  typedef struct packed {
    logic tck;   // Test clock level.
    logic tms;   // Test mode select level.
    logic tdi;   // Test data input level.
    logic trst;  // Test reset, active low.
  } bst_pins_t;

  // Edge events found on the test clock.
  typedef struct packed {
    logic rise;  // Rising test clock edge seen.
    logic fall;  // Falling test clock edge seen.
  } bst_edges_t;

endpackage : bst_pkg

// >>> design/bst_sync.sv
// Three-flop synchroniser with edge finding for the test pins.
`timescale 1ns/1ps
module bst_sync
  import bst_pkg::*;
(
  input  wire logic       mclk,   // System clock.
  input  wire logic       rstn,   // Synchronous reset, active low.
  input  wire bst_pkg::bst_pins_t  pins,   // Raw test pin levels.
  output bst_pkg::bst_pins_t       level,  // Filtered pin levels.
  output bst_pkg::bst_edges_t      edges   // Test clock edges, one-cycle pulses.
);

  // Idle pin levels: clock low, pulled-up inputs high, so no false edge or level change follows reset.
  localparam bst_pins_t PINS_IDLE = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst: 1'b1};

  bst_pins_t s1;       // First stage, read only by the second.
  bst_pins_t s2;       // Second stage.
  bst_pins_t s3;       // Third stage.
  bst_pins_t next_level;  // Next filtered value.
  bst_edges_t next_edges; // Next edge pulses.

  // A bit changes only once the second and third stages agree, which rejects a single metastable sample.
  always_comb
  begin
    next_level = level;
    next_edges = '0;
    for (int i = 0; i < $bits(bst_pins_t); i++)
    begin
      if (s2[i] == s3[i])
      begin
        next_level[i] = s3[i];
      end
    end
    next_edges.rise = next_level.tck & ~level.tck;
    next_edges.fall = ~next_level.tck & level.tck;
  end

  // Registers only; reset loads the idle pin levels that the pull-ups give.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      s1    <= PINS_IDLE;
      s2    <= PINS_IDLE;
      s3    <= PINS_IDLE;
      level <= PINS_IDLE;
      edges <= '0;
    end
    else
    begin
      s1    <= pins;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
      edges <= next_edges;
    end
  end

endmodule : bst_sync

// >>> design/bst_tap.sv
// Boundary-scan test access port controller with bypass and boundary chain.
`timescale 1ns/1ps
// Operation
// - Test reset low forces controller reset after the pin filter delay, without a clock edge.
// - Data input captured on rising test clock.
// - Data output updated on falling test clock.
// - Mode select steers sixteen-state controller.
// - Output three-stated unless shifting.
// - Digital pins scanned in test mode.
// - Output clock pins have no cell.
module bst_tap
  import bst_pkg::*;
#(
  parameter int unsigned PINS = BST_PINS  // Scanned digital pin count.
)
(
  input  wire logic             mclk,                 // System clock, 125 MHz.
  input  wire logic             rstn,                 // Synchronous reset, active low.
  input  wire logic             test_reset_n,         // Test reset pin, active low.
  input  wire logic             test_clock,           // Test clock pin.
  input  wire logic             test_mode_select,     // Test mode select pin.
  input  wire logic             test_data_in,         // Test data input pin.
  output logic                  test_data_out,        // Test data output value.
  output logic                  test_data_out_oe_n,   // Output enable, low while driving.
  input  wire logic [PINS-1:0]  core_out,             // Functional pin drive from the core.
  input  wire logic [PINS-1:0]  core_oe_n,            // Functional enable, low drives.
  input  wire logic [PINS-1:0]  pad_in,               // Levels seen at the pads.
  output logic      [PINS-1:0]  pad_out,              // Value sent to the pads.
  output logic      [PINS-1:0]  pad_oe_n,             // Pad enable, low drives.
  output logic      [PINS-1:0]  core_in,              // Pad levels passed to the core.
  input  wire logic [PINS-1:0]  clock_out_core,       // Output clocks from the synthesiser.
  output logic      [PINS-1:0]  output_clock_pins,    // Output clocks to their pads.
  output logic                  test_mode             // EXTEST is active.
);

  bst_pins_t          lvl;          // Filtered pin levels.
  bst_edges_t         edg;          // Test clock edges.
  bst_state_t         state;        // Controller state.
  bst_state_t         next_state;   // Next controller state.
  logic [BST_IR_W-1:0] ir_shift;    // Instruction shift stage.
  logic [BST_IR_W-1:0] ir;          // Active instruction.
  logic               bypass;       // Bypass bit.
  logic [2*PINS-1:0]  bsr_shift;    // Boundary shift stage, data and enable per pin.
  logic [2*PINS-1:0]  bsr_upd;      // Boundary update latches.
  logic [BST_IR_W-1:0] next_ir_shift;
  logic [BST_IR_W-1:0] next_ir;
  logic               next_bypass;
  logic [2*PINS-1:0]  next_bsr_shift;
  logic [2*PINS-1:0]  next_bsr_upd;
  logic               next_tdo;
  logic               next_tdo_oe_n;
  logic [PINS-1:0]    next_pad_out;
  logic [PINS-1:0]    next_pad_oe_n;
  logic [PINS-1:0]    next_core_in;
  logic               next_test_mode;

  // The test clock is sampled, not used as a clock, so all logic stays on mclk.
  bst_sync u_sync (
    .mclk  (mclk),
    .rstn  (rstn),
    .pins  ({test_clock, test_mode_select, test_data_in, test_reset_n}),
    .level (lvl),
    .edges (edg)
  );

  // Next state of the sixteen-state controller from mode select.
  function automatic bst_state_t tap_next(input bst_state_t s, input logic m);
    unique case (s)
      BST_RESET:    tap_next = m ? BST_RESET    : BST_IDLE;
      BST_IDLE:     tap_next = m ? BST_SEL_DR   : BST_IDLE;
      BST_SEL_DR:   tap_next = m ? BST_SEL_IR   : BST_CAP_DR;
      BST_CAP_DR:   tap_next = m ? BST_EXIT1_DR : BST_SHIFT_DR;
      BST_SHIFT_DR: tap_next = m ? BST_EXIT1_DR : BST_SHIFT_DR;
      BST_EXIT1_DR: tap_next = m ? BST_UPD_DR   : BST_PAUSE_DR;
      BST_PAUSE_DR: tap_next = m ? BST_EXIT2_DR : BST_PAUSE_DR;
      BST_EXIT2_DR: tap_next = m ? BST_UPD_DR   : BST_SHIFT_DR;
      BST_UPD_DR:   tap_next = m ? BST_SEL_DR   : BST_IDLE;
      BST_SEL_IR:   tap_next = m ? BST_RESET    : BST_CAP_IR;
      BST_CAP_IR:   tap_next = m ? BST_EXIT1_IR : BST_SHIFT_IR;
      BST_SHIFT_IR: tap_next = m ? BST_EXIT1_IR : BST_SHIFT_IR;
      BST_EXIT1_IR: tap_next = m ? BST_UPD_IR   : BST_PAUSE_IR;
      BST_PAUSE_IR: tap_next = m ? BST_EXIT2_IR : BST_PAUSE_IR;
      BST_EXIT2_IR: tap_next = m ? BST_UPD_IR   : BST_SHIFT_IR;
      BST_UPD_IR:   tap_next = m ? BST_SEL_DR   : BST_IDLE;
    endcase
  endfunction : tap_next

  // True when the active instruction routes the boundary chain between the data pins.
  function automatic logic uses_chain(input logic [BST_IR_W-1:0] op);
    uses_chain = (op == BST_OP_EXTEST) || (op == BST_OP_SAMPLE);
  endfunction : uses_chain

  // Picks the data cell (odd low) or enable cell (odd high) of every pin from a chain image.
  function automatic logic [PINS-1:0] cell_pick(input logic [2*PINS-1:0] v, input logic odd);
    for (int i = 0; i < PINS; i++)
    begin
      cell_pick[i] = v[2*i+int'(odd)];
    end
  endfunction : cell_pick

  // Controller and scan register updates happen on a sampled rising edge; test reset and the output take no rising edge.
  always_comb
  begin
    next_state     = state;
    next_ir_shift  = ir_shift;
    next_ir        = ir;
    next_bypass    = bypass;
    next_bsr_shift = bsr_shift;
    next_bsr_upd   = bsr_upd;
    next_tdo       = test_data_out;
    next_tdo_oe_n  = test_data_out_oe_n;
    // Test reset wins without any clock edge; only the filter delay applies.
    if (!lvl.trst)
    begin
      next_state    = BST_RESET;
      next_ir       = BST_OP_BYPASS;
      next_tdo_oe_n = 1'b1;
    end
    else
    begin
      if (edg.rise)
      begin
        next_state = tap_next(state, lvl.tms);
        unique case (state)
          BST_RESET:
          begin
            next_ir = BST_OP_BYPASS;
          end
          BST_CAP_IR:
          begin
            next_ir_shift = BST_IR_CAPTURE;
          end
          BST_SHIFT_IR:
          begin
            next_ir_shift = {lvl.tdi, ir_shift[BST_IR_W-1:1]};
          end
          BST_UPD_IR:
          begin
            next_ir = ir_shift;
          end
          BST_CAP_DR:
          begin
            next_bypass = 1'b0;
            for (int i = 0; i < PINS; i++)
            begin
              next_bsr_shift[2*i]   = pad_in[i];
              next_bsr_shift[2*i+1] = core_oe_n[i];
            end
          end
          BST_SHIFT_DR:
          begin
            if (uses_chain(ir))
            begin
              next_bsr_shift = {lvl.tdi, bsr_shift[2*PINS-1:1]};
            end
            else
            begin
              next_bypass = lvl.tdi;
            end
          end
          BST_UPD_DR:
          begin
            if (uses_chain(ir))
            begin
              next_bsr_upd = bsr_shift;
            end
          end
          default:
          begin
            next_bypass = bypass;
          end
        endcase
      end
      // Output moves only on the falling edge, half a cycle after capture.
      if (edg.fall)
      begin
        if (state == BST_SHIFT_IR)
        begin
          next_tdo      = ir_shift[0];
          next_tdo_oe_n = 1'b0;
        end
        else if (state == BST_SHIFT_DR)
        begin
          next_tdo      = uses_chain(ir) ? bsr_shift[0] : bypass;
          next_tdo_oe_n = 1'b0;
        end
        else
        begin
          next_tdo_oe_n = 1'b1;
        end
      end
    end
  end

  // Pad muxing; output clocks bypass the chain entirely.
  always_comb
  begin
    next_test_mode = (ir == BST_OP_EXTEST);
    next_core_in   = pad_in;
    next_pad_out   = next_test_mode ? cell_pick(bsr_upd, 1'b0) : core_out;
    next_pad_oe_n  = next_test_mode ? cell_pick(bsr_upd, 1'b1) : core_oe_n;
  end

  // Registers only.
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state              <= BST_RESET;
      ir_shift           <= BST_IR_CAPTURE;
      ir                 <= BST_OP_BYPASS;
      bypass             <= 1'b0;
      bsr_shift          <= '0;
      bsr_upd            <= '0;
      test_data_out      <= 1'b0;
      test_data_out_oe_n <= 1'b1;
      pad_out            <= '0;
      pad_oe_n           <= '1;
      core_in            <= '0;
      test_mode          <= 1'b0;
      output_clock_pins  <= '0;
    end
    else
    begin
      state              <= next_state;
      ir_shift           <= next_ir_shift;
      ir                 <= next_ir;
      bypass             <= next_bypass;
      bsr_shift          <= next_bsr_shift;
      bsr_upd            <= next_bsr_upd;
      test_data_out      <= next_tdo;
      test_data_out_oe_n <= next_tdo_oe_n;
      pad_out            <= next_pad_out;
      pad_oe_n           <= next_pad_oe_n;
      core_in            <= next_core_in;
      test_mode          <= next_test_mode;
      output_clock_pins  <= clock_out_core;
    end
  end

  // Test reset held low leads to the reset state within a few cycles.
  AST_TRST_RESET: assert property (@(posedge mclk) disable iff (!rstn)
    (!lvl.trst) |=> (state == BST_RESET)) else $error("Test reset did not reset the controller.");

  // Output only changes right after a falling edge.
  AST_TDO_FALL: assert property (@(posedge mclk) disable iff (!rstn)
    $changed(test_data_out) |-> $past(edg.fall)) else $error("Data output changed off the falling edge.");

  // Output driven only after shifting states.
  AST_TDO_Z: assert property (@(posedge mclk) disable iff (!rstn)
    (!test_data_out_oe_n && !$past(test_data_out_oe_n)) || test_data_out_oe_n
    || $past(state == BST_SHIFT_IR || state == BST_SHIFT_DR)) else $error("Output enabled outside shifting.");

  // State only moves on a rising edge or test reset.
  AST_TMS_STEP: assert property (@(posedge mclk) disable iff (!rstn)
    $changed(state) |-> $past(edg.rise) || !$past(lvl.trst)) else $error("State moved without an edge.");

  // A rising edge with mode select high in Select-IR reaches reset, the last of five such steps.
  AST_FIVE_ONES: assert property (@(posedge mclk) disable iff (!rstn)
    (edg.rise && lvl.tms && state == BST_SEL_IR && lvl.trst) |=> (state == BST_RESET))
    else $error("Select IR with mode high missed reset.");

  // Reset state loads bypass.
  AST_RESET_BYPASS: assert property (@(posedge mclk) disable iff (!rstn)
    (state == BST_RESET && edg.rise) |=> (ir == BST_OP_BYPASS)) else $error("Bypass not loaded in reset.");

  // EXTEST drives every pad value and enable from its own update cell one cycle later.
  AST_EXTEST_PAD: assert property (@(posedge mclk) disable iff (!rstn)
    (ir == BST_OP_EXTEST) |=> ((pad_out == cell_pick($past(bsr_upd), 1'b0))
    && (pad_oe_n == cell_pick($past(bsr_upd), 1'b1)))) else $error("Pad not driven by chain.");

  // Output clocks follow the core one cycle later in any mode.
  AST_OC_PASS: assert property (@(posedge mclk) disable iff (!rstn)
    1'b1 |=> (output_clock_pins == $past(clock_out_core))) else $error("Output clocks were captured by test.");

endmodule : bst_tap

// >>> tb/bst_host.sv
// Model of the external test host that clocks the scan pins.
`timescale 1ns/1ps
module bst_host
#(
  parameter int HALF = 7  // Test clock half period in system clock cycles.
)
(
  input  wire logic        mclk,  // System clock that paces the model.
  input  wire logic        tdo,   // Scan output value.
  input  wire logic        oe_n,  // Scan output enable, low drives.
  output logic             tck,   // Test clock, still between frames.
  output logic             tms,   // Mode select, pulled up when idle.
  output logic             tdi,   // Data input, pulled up when idle.
  output logic             done,  // Pulses once a frame result is ready.
  output logic      [15:0] rx     // Bits read back, first bit lowest.
);
  // A released output floats, so reading it then gives no valid bit.
  wire logic pin = oe_n ? 1'bz : tdo;

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    done = 1'b0;
    rx = '0;
  end

  // One clock: inputs move while the clock is low, the output is read just before the fall.
  task automatic clk_bit(input logic m, input logic d, output logic q);
    @(negedge mclk);
    tms = m;
    tdi = d;
    repeat (HALF) @(negedge mclk);
    tck = 1'b1;
    repeat (HALF) @(negedge mclk);
    q = pin;
    tck = 1'b0;
  endtask : clk_bit

  // Walks from idle through one instruction or data scan of n bits and back to idle.
  task automatic scan(input logic ir, input logic [15:0] d, input int n);
    logic q;
    rx = '0;
    clk_bit(1'b1, 1'b0, q);
    if (ir)
    begin
      clk_bit(1'b1, 1'b0, q);
    end
    clk_bit(1'b0, 1'b0, q);
    clk_bit(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      clk_bit(i == n - 1, d[i], q);
      rx[i] = q;
    end
    clk_bit(1'b1, 1'b0, q);
    clk_bit(1'b0, 1'b0, q);
    tms = 1'b1;
    tdi = 1'b1;
    done = 1'b1;
    @(negedge mclk);
    done = 1'b0;
  endtask : scan

  // Five clocks with mode select high reach reset from any state, then step to idle.
  task automatic tms_reset();
    logic q;
    repeat (5) clk_bit(1'b1, 1'b1, q);
    clk_bit(1'b0, 1'b1, q);
  endtask : tms_reset
endmodule : bst_host

// >>> tb/tb_bst_tap.sv
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/1ps
module tb_bst_tap;
  import bst_pkg::*;
  logic                mclk, rstn, trst_n, tdo, oe_n, test_mode, tck, tms, tdi, done;
  logic [BST_PINS-1:0] core_out, core_oe_n, pad_in, pad_out, pad_oe_n, core_in, clk_core, clk_pins;
  logic [15:0]         rx, seed, p;
  logic [15:0]         exp_q[$];  // Expected scan results, oldest first.
  int                  miscompares, comparisons;

  bst_tap #(.PINS(BST_PINS)) i_bst_tap (.mclk(mclk), .rstn(rstn), .test_reset_n(trst_n),
    .test_clock(tck), .test_mode_select(tms), .test_data_in(tdi), .test_data_out(tdo),
    .test_data_out_oe_n(oe_n), .core_out(core_out), .core_oe_n(core_oe_n), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .core_in(core_in), .clock_out_core(clk_core),
    .output_clock_pins(clk_pins), .test_mode(test_mode));
  bst_host #(.HALF(7)) i_bst_host (.mclk(mclk), .tdo(tdo), .oe_n(oe_n), .tck(tck), .tms(tms),
    .tdi(tdi), .done(done), .rx(rx));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Sixteen-bit shift register that feeds random pin values.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Chain order puts pin data on even bits and pin enables on odd bits.
  function automatic logic [15:0] weave(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] r;
    for (int i = 0; i < 8; i++)
    begin
      r[2*i] = a[i];
      r[2*i+1] = b[i];
    end
    return r;
  endfunction : weave

  function automatic logic [7:0] pick(input logic [15:0] v, input int o);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[2*i+o];
    end
    return r;
  endfunction : pick

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Every instruction scan reads back the fixed capture pattern.
  task automatic ir_scan(input logic [3:0] op);
    exp_q.push_back({12'h0, BST_IR_CAPTURE});
    i_bst_host.scan(1'b1, {12'h0, op}, 4);
  endtask : ir_scan

  task automatic dr_scan(input logic [15:0] d, input int n, input logic [15:0] e);
    exp_q.push_back(e);
    i_bst_host.scan(1'b0, d, n);
  endtask : dr_scan

  task automatic settle();
    repeat (12) @(negedge mclk);
  endtask : settle

  task automatic print_verdict();
    if (exp_q.size() != 0)
    begin
      miscompares++;
      $display("ERROR %0t: scan results missing", $time);
    end
    if (miscompares == 0 && comparisons > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // Compares each finished scan against the oldest expectation.
  always @(posedge done)
  begin
    if (exp_q.size() > 0)
    begin
      check(rx, exp_q.pop_front());
    end
    else
    begin
      miscompares++;
      $display("ERROR %0t: unexpected scan result", $time);
    end
  end

  // A hang is cut short here and counts as a mismatch.
  initial
  begin
    #400000;
    miscompares++;
    $display("ERROR %0t: timeout", $time);
    print_verdict();
  end

  initial
  begin
    rstn = 1'b0;
    trst_n = 1'b1;
    seed = 16'h19d9;
    core_out = '0;
    core_oe_n = '1;
    pad_in = '0;
    clk_core = '0;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    settle();
    i_bst_host.tms_reset();
    ir_scan(BST_OP_BYPASS);
    seed = lfsr(seed);
    dr_scan(seed, 8, {8'h0, seed[6:0], 1'b0});
    ir_scan(BST_OP_SAMPLE);
    seed = lfsr(seed);
    pad_in = seed[7:0];
    core_oe_n = seed[15:8];
    seed = lfsr(seed);
    core_out = seed[7:0];
    clk_core = seed[15:8];
    p = lfsr(seed);
    dr_scan(p, 16, weave(pad_in, core_oe_n));
    settle();
    check({15'h0, oe_n}, 16'h1);
    check({8'h0, pad_out}, {8'h0, core_out});
    check({8'h0, core_in}, {8'h0, pad_in});
    check({8'h0, clk_pins}, {8'h0, clk_core});
    ir_scan(BST_OP_EXTEST);
    seed = lfsr(p);
    clk_core = seed[7:0];
    settle();
    check({15'h0, test_mode}, 16'h1);
    check({8'h0, pad_out}, {8'h0, pick(p, 0)});
    check({8'h0, pad_oe_n}, {8'h0, pick(p, 1)});
    check({8'h0, clk_pins}, {8'h0, clk_core});
    trst_n = 1'b0;
    repeat (8) @(negedge mclk);
    trst_n = 1'b1;
    settle();
    check({15'h0, test_mode}, 16'h0);
    check({15'h0, oe_n}, 16'h1);
    i_bst_host.tms_reset();
    seed = lfsr(seed);
    dr_scan(seed, 8, {8'h0, seed[6:0], 1'b0});
    ir_scan(BST_OP_SAMPLE);
    i_bst_host.tms_reset();
    seed = lfsr(seed);
    dr_scan(seed, 8, {8'h0, seed[6:0], 1'b0});
    print_verdict();
  end
endmodule : tb_bst_tap
